//--- tdam_defines.vh
// Offsets, fields, reset values and select codes of the test and diagnostic register bank
`ifndef TDAM_DEFINES_VH
`define TDAM_DEFINES_VH

// =====================================================================
// Register offsets
`define TDAM_ADDR_W 6
`define TDAM_OFF_SELF_TEST 6'h36
`define TDAM_OFF_CHIP_ID 6'h37
`define TDAM_OFF_AUX_SEL 6'h38
`define TDAM_OFF_PROBE_ONE 6'h39
`define TDAM_OFF_PROBE_TWO 6'h3a
`define TDAM_OFF_PROBE_SEL1 6'h31
`define TDAM_OFF_PROBE_SEL2 6'h32

// =====================================================================
// Reset values
`define TDAM_RST_SELF_TEST 8'h40
`define TDAM_RST_AUX_SEL 8'h00
`define TDAM_RST_PROBE 6'h00
`define TDAM_RST_SEL 8'h00

// =====================================================================
// Field positions
`define TDAM_NONLIN_BIT 6
`define TDAM_CHECK_MSB 3
`define TDAM_CHECK_LSB 0
`define TDAM_CHECK_ON 4'h9
`define TDAM_CMD_CHECKSUM 4'h3

// =====================================================================
// Aux source select codes
`define TDAM_SRC_HIZ 4'h0
`define TDAM_SRC_DAC 4'h1
`define TDAM_SRC_CORR 4'h2
`define TDAM_SRC_MINLVL 4'h4
`define TDAM_SRC_ADC_I 4'h5
`define TDAM_SRC_ADC_Q 4'h6
`define TDAM_SRC_PROD 4'h8
`define TDAM_SRC_HIGH 4'ha
`define TDAM_SRC_LOW 4'hb
`define TDAM_SRC_TXACT 4'hc
`define TDAM_SRC_RXACT 4'hd
`define TDAM_SRC_SUBC 4'he
`define TDAM_SRC_TBUS 4'hf

`endif

//--- tdam_sync.v
// Three-stage synchroniser for an asynchronous level input
`timescale 1ns/1ps
module tdam_sync (
   input wire clk_i,   // System clock
   input wire rst_i,   // Async reset, active high
   input wire d_i,     // Asynchronous level
   output reg q_o      // Filtered synchronous level
);
   reg s1;
   reg s2;
   reg s3;
   // A change counts only once stages two and three agree
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         s1 <= 1'b0;
         s2 <= 1'b0;
         s3 <= 1'b0;
         q_o <= 1'b0;
      end else begin
         s1 <= d_i;
         s2 <= s1;
         s3 <= s2;
         if (s2 == s3) begin
            q_o <= s3;
         end
      end
   end
endmodule // tdam_sync

//--- tdam_aux_mux.v
// Source multiplexer for one analog auxiliary pin
`timescale 1ns/1ps
`include "tdam_defines.vh"
module tdam_aux_mux #(
   parameter W = 6
) (
   input wire [3:0] sel_i,      // Source select code
   input wire [W-1:0] dac_i,    // Probe DAC value for this pin
   input wire [W-1:0] corr_i,   // Correlator probe
   input wire [W-1:0] minlvl_i, // Minimum threshold probe
   input wire [W-1:0] adc_i_i,  // In-phase sample
   input wire [W-1:0] adc_q_i,  // Quadrature sample
   input wire tx_act_i,         // Transmit activity flag
   input wire rx_act_i,         // Receive activity flag
   input wire subc_i,           // Subcarrier detected
   input wire tbus_bit_i,       // Picked test-bus bit
   output reg [W-1:0] level_o,  // Analog level code
   output reg oe_n_o            // Low while the pin is driven
);
   always @* begin
      level_o = {W{1'b0}};
      oe_n_o = 1'b0;
      case (sel_i)
         `TDAM_SRC_DAC: level_o = dac_i;
         `TDAM_SRC_CORR: level_o = corr_i;
         `TDAM_SRC_MINLVL: level_o = minlvl_i;
         `TDAM_SRC_ADC_I: level_o = adc_i_i;
         `TDAM_SRC_ADC_Q: level_o = adc_q_i;
         `TDAM_SRC_HIGH: level_o = {W{1'b1}};
         `TDAM_SRC_LOW: level_o = {W{1'b0}};
         `TDAM_SRC_TXACT: level_o = {W{tx_act_i}};
         `TDAM_SRC_RXACT: level_o = {W{rx_act_i}};
         `TDAM_SRC_SUBC: level_o = {W{subc_i}};
         `TDAM_SRC_TBUS: level_o = {W{tbus_bit_i}};
         // Codes 0000, 0011, 0111, 1000 and 1001 leave the pin floating
         default: oe_n_o = 1'b1;
      endcase
   end
endmodule // tdam_aux_mux

//--- tdam_regs.v
// Test and diagnostic register bank with the two auxiliary pin source multiplexers
`timescale 1ns/1ps
`include "tdam_defines.vh"
module tdam_regs #(
   parameter [3:0] CHIP_TYPE = 4'h5,  // Arbitrary value
   parameter [3:0] CHIP_REV = 4'h3,   // Arbitrary value
   parameter DAC_W = 6
) (
   input wire CLK_SYS_I,                       // 200 MHz system clock
   input wire SYS_RST_I,                       // Async reset, active high
   input wire [`TDAM_ADDR_W-1:0] REG_ADDR_I,   // Register address
   input wire [7:0] REG_WDATA_I,               // Write data
   input wire REG_WR_I,                        // Write strobe
   input wire REG_RD_I,                        // Read strobe
   output reg [7:0] REG_RDATA_O,               // Read data, cycle after strobe
   input wire CMD_VALID_I,                     // Command code issued
   input wire [3:0] CMD_CODE_I,                // Command code
   input wire [DAC_W-1:0] CORR_I,              // Correlator probe
   input wire [DAC_W-1:0] MINLVL_I,            // Minimum threshold probe
   input wire [DAC_W-1:0] ADC_I_I,             // In-phase sample
   input wire [DAC_W-1:0] ADC_Q_I,             // Quadrature sample
   input wire TX_ACT_I,                        // Transmit activity, same clock
   input wire RX_ACT_I,                        // Receive activity, same clock
   input wire SUBC_DET_I,                      // Subcarrier detect, async
   input wire [7:0] TEST_BUS_I,                // Internal test bus, same clock
   output reg SELF_TEST_EN_O,                  // Digital self-test enable
   output reg SELF_TEST_START_O,               // Self-test launch pulse
   output reg RX_NONLINEAR_O,                  // Nonlinear receiver gain mode
   output reg [4:0] TEST_BUS_SEL_O,            // Test bus source select
   output reg [DAC_W-1:0] AUX_ONE_LEVEL_O,     // Pin one level code
   output reg AUX_ONE_OE_N_O,                  // Pin one drive enable, low drives
   output reg [DAC_W-1:0] AUX_TWO_LEVEL_O,     // Pin two level code
   output reg AUX_TWO_OE_N_O                   // Pin two drive enable, low drives
);
   // =====================================================================
   // Register storage
   reg [7:0] self_test_control;
   reg [7:0] aux_pin_source_select;
   reg [DAC_W-1:0] probe_level_one;
   reg [DAC_W-1:0] probe_level_two;
   reg [1:0] probe_one_spare;
   reg [7:0] first_probe_select_register;
   reg [7:0] second_probe_select_register;
   reg subc_sync;
   wire [3:0] digital_check_select;
   wire [3:0] aux_one_source_select;
   wire [3:0] aux_two_source_select;
   wire [2:0] probe_bit_pick;
   wire probe_bit;
   wire [DAC_W-1:0] lvl_one;
   wire [DAC_W-1:0] lvl_two;
   wire oe_one_n;
   wire oe_two_n;
   reg [7:0] next_rdata;

   assign digital_check_select = self_test_control[`TDAM_CHECK_MSB:`TDAM_CHECK_LSB];
   assign aux_one_source_select = aux_pin_source_select[7:4];
   assign aux_two_source_select = aux_pin_source_select[3:0];
   assign probe_bit_pick = first_probe_select_register[2:0];
   assign probe_bit = TEST_BUS_I[probe_bit_pick];

   // =====================================================================
   // Write decode; identification and unmapped offsets get no strobe
   wire wr_self_test = REG_WR_I && (REG_ADDR_I == `TDAM_OFF_SELF_TEST);
   wire wr_aux_sel = REG_WR_I && (REG_ADDR_I == `TDAM_OFF_AUX_SEL);
   wire wr_probe_one = REG_WR_I && (REG_ADDR_I == `TDAM_OFF_PROBE_ONE);
   wire wr_probe_two = REG_WR_I && (REG_ADDR_I == `TDAM_OFF_PROBE_TWO);
   wire wr_probe_sel1 = REG_WR_I && (REG_ADDR_I == `TDAM_OFF_PROBE_SEL1);
   wire wr_probe_sel2 = REG_WR_I && (REG_ADDR_I == `TDAM_OFF_PROBE_SEL2);

   // =====================================================================
   // Self-test control; factory bits are held as storage only, they steer nothing
   always @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         self_test_control <= `TDAM_RST_SELF_TEST;
      end else if (wr_self_test) begin
         self_test_control <= REG_WDATA_I;
      end
   end

   // =====================================================================
   // Auxiliary pin source select
   always @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         aux_pin_source_select <= `TDAM_RST_AUX_SEL;
      end else if (wr_aux_sel) begin
         aux_pin_source_select <= REG_WDATA_I;
      end
   end

   // =====================================================================
   // Probe DAC one; the spare bits read back but never reach a pin
   always @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         probe_level_one <= `TDAM_RST_PROBE;
         probe_one_spare <= 2'h0;
      end else if (wr_probe_one) begin
         probe_level_one <= REG_WDATA_I[DAC_W-1:0];
         probe_one_spare <= REG_WDATA_I[7:6];
      end
   end

   // =====================================================================
   // Probe DAC two; its upper bits are not stored and read as zero
   always @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         probe_level_two <= `TDAM_RST_PROBE;
      end else if (wr_probe_two) begin
         probe_level_two <= REG_WDATA_I[DAC_W-1:0];
      end
   end

   // =====================================================================
   // Test-bus bit pick and test-bus source select
   always @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         first_probe_select_register <= `TDAM_RST_SEL;
      end else if (wr_probe_sel1) begin
         first_probe_select_register <= REG_WDATA_I;
      end
   end

   always @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         second_probe_select_register <= `TDAM_RST_SEL;
      end else if (wr_probe_sel2) begin
         second_probe_select_register <= REG_WDATA_I;
      end
   end

   // =====================================================================
   // Read path
   always @* begin
      case (REG_ADDR_I)
         `TDAM_OFF_SELF_TEST: next_rdata = self_test_control;
         `TDAM_OFF_CHIP_ID: next_rdata = {CHIP_TYPE, CHIP_REV};
         `TDAM_OFF_AUX_SEL: next_rdata = aux_pin_source_select;
         `TDAM_OFF_PROBE_ONE: next_rdata = {probe_one_spare, probe_level_one};
         `TDAM_OFF_PROBE_TWO: next_rdata = {2'h0, probe_level_two};
         `TDAM_OFF_PROBE_SEL1: next_rdata = first_probe_select_register;
         `TDAM_OFF_PROBE_SEL2: next_rdata = second_probe_select_register;
         default: next_rdata = 8'h00;
      endcase
   end

   // Read data is valid only in the cycle after the strobe
   always @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         REG_RDATA_O <= 8'h00;
      end else if (REG_RD_I) begin
         REG_RDATA_O <= next_rdata;
      end else begin
         REG_RDATA_O <= 8'h00;
      end
   end

   // =====================================================================
   // Self-test enable; software must clear the selector before normal use
   always @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         SELF_TEST_EN_O <= 1'b0;
      end else begin
         SELF_TEST_EN_O <= (digital_check_select == `TDAM_CHECK_ON);
      end
   end

   // Launch needs the enable pattern plus the checksum command
   always @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         SELF_TEST_START_O <= 1'b0;
      end else begin
         SELF_TEST_START_O <= CMD_VALID_I && (CMD_CODE_I == `TDAM_CMD_CHECKSUM)
            && (digital_check_select == `TDAM_CHECK_ON);
      end
   end

   // =====================================================================
   // Receiver gain mode and test-bus source
   always @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         RX_NONLINEAR_O <= 1'b1;
      end else begin
         RX_NONLINEAR_O <= self_test_control[`TDAM_NONLIN_BIT];
      end
   end

   always @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         TEST_BUS_SEL_O <= 5'h00;
      end else begin
         TEST_BUS_SEL_O <= second_probe_select_register[4:0];
      end
   end

   // =====================================================================
   // Subcarrier detect arrives from the analog side, so it is synchronised
   tdam_sync u_subc_sync (
      .clk_i(CLK_SYS_I),
      .rst_i(SYS_RST_I),
      .d_i(SUBC_DET_I),
      .q_o(subc_sync)
   );

   // =====================================================================
   // Auxiliary pin multiplexers
   tdam_aux_mux #(.W(DAC_W)) u_mux_one (
      .sel_i(aux_one_source_select),
      .dac_i(probe_level_one),
      .corr_i(CORR_I),
      .minlvl_i(MINLVL_I),
      .adc_i_i(ADC_I_I),
      .adc_q_i(ADC_Q_I),
      .tx_act_i(TX_ACT_I),
      .rx_act_i(RX_ACT_I),
      .subc_i(subc_sync),
      .tbus_bit_i(probe_bit),
      .level_o(lvl_one),
      .oe_n_o(oe_one_n)
   );

   tdam_aux_mux #(.W(DAC_W)) u_mux_two (
      .sel_i(aux_two_source_select),
      .dac_i(probe_level_two),
      .corr_i(CORR_I),
      .minlvl_i(MINLVL_I),
      .adc_i_i(ADC_I_I),
      .adc_q_i(ADC_Q_I),
      .tx_act_i(TX_ACT_I),
      .rx_act_i(RX_ACT_I),
      .subc_i(subc_sync),
      .tbus_bit_i(probe_bit),
      .level_o(lvl_two),
      .oe_n_o(oe_two_n)
   );

   // Registered so the pins see no decode glitches; costs one cycle of lag
   always @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         AUX_ONE_LEVEL_O <= {DAC_W{1'b0}};
         AUX_ONE_OE_N_O <= 1'b1;
         AUX_TWO_LEVEL_O <= {DAC_W{1'b0}};
         AUX_TWO_OE_N_O <= 1'b1;
      end else begin
         AUX_ONE_LEVEL_O <= lvl_one;
         AUX_ONE_OE_N_O <= oe_one_n;
         AUX_TWO_LEVEL_O <= lvl_two;
         AUX_TWO_OE_N_O <= oe_two_n;
      end
   end
endmodule // tdam_regs

//--- tdam_regs_monitor.sv
// Port checker for the test and diagnostic register bank
`timescale 1ns/1ps
`include "tdam_defines.vh"
module tdam_regs_monitor #(
   parameter [3:0] CHIP_TYPE = 4'h5, // Arbitrary value
   parameter [3:0] CHIP_REV = 4'h3,  // Arbitrary value
   parameter DAC_W = 6
) (
   input wire CLK_SYS_I,                     // Clock
   input wire SYS_RST_I,                     // Reset
   input wire [`TDAM_ADDR_W-1:0] REG_ADDR_I, // Address
   input wire [7:0] REG_WDATA_I,             // Write data
   input wire REG_WR_I,                      // Write strobe
   input wire REG_RD_I,                      // Read strobe
   input wire [7:0] REG_RDATA_O,             // Read data
   input wire CMD_VALID_I,                   // Command strobe
   input wire [3:0] CMD_CODE_I,              // Command code
   input wire TX_ACT_I,                      // Transmit activity
   input wire SELF_TEST_EN_O,                // Self-test enable
   input wire SELF_TEST_START_O,             // Self-test launch
   input wire RX_NONLINEAR_O,                // Nonlinear gain
   input wire [DAC_W-1:0] AUX_ONE_LEVEL_O,   // Pin one level
   input wire AUX_ONE_OE_N_O,                // Pin one float
   input wire [DAC_W-1:0] AUX_TWO_LEVEL_O,   // Pin two level
   input wire AUX_TWO_OE_N_O                 // Pin two float
);
   // ====================================================================
   // Helper logic
   wire wr_st = REG_WR_I && (REG_ADDR_I == `TDAM_OFF_SELF_TEST);
   wire wr_aux = REG_WR_I && (REG_ADDR_I == `TDAM_OFF_AUX_SEL);
   reg [3:0] aux_two_sel;
   always @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
      if (SYS_RST_I)
         aux_two_sel <= 4'h0;
      else if (wr_aux)
         aux_two_sel <= REG_WDATA_I[3:0];
   end
   function automatic logic fl(input logic [3:0] c);
      return (c == 4'h0) || (c == 4'h3) || (c == 4'h7) || (c == 4'h8) || (c == 4'h9);
   endfunction
   default clocking cb @(posedge CLK_SYS_I); endclocking
   default disable iff (SYS_RST_I);
   // ====================================================================
   // Assertions
   st_en_a: assert property (wr_st |-> ##2
      SELF_TEST_EN_O == ($past(REG_WDATA_I[3:0], 2) == 4'h9)) else $error("self-test enable wrong");
   nonlin_mode_a: assert property (wr_st |-> ##2
      RX_NONLINEAR_O == $past(REG_WDATA_I[6], 2)) else $error("nonlinear mode wrong");
   st_launch_a: assert property ($rose(SELF_TEST_START_O) |->
      $past(CMD_VALID_I) && $past(CMD_CODE_I) == 4'h3) else $error("launch without command");
   id_read_a: assert property (REG_RD_I && REG_ADDR_I == `TDAM_OFF_CHIP_ID |=>
      REG_RDATA_O == {CHIP_TYPE, CHIP_REV}) else $error("identification wrong");
   rdata_idle_a: assert property (!REG_RD_I || REG_ADDR_I < 6'h31 |=>
      REG_RDATA_O == 8'h00) else $error("read data not zero");
   pin_float_a: assert property (wr_aux |-> ##2
      AUX_ONE_OE_N_O == fl($past(REG_WDATA_I[7:4], 2))
      && AUX_TWO_OE_N_O == fl($past(REG_WDATA_I[3:0], 2))) else $error("pin float wrong");
   const_hi_a: assert property (wr_aux && REG_WDATA_I[7:4] == 4'ha |-> ##2
      AUX_ONE_LEVEL_O == 6'h3f) else $error("constant high wrong");
   tx_path_a: assert property (aux_two_sel == 4'hc |=> !AUX_TWO_OE_N_O
      && AUX_TWO_LEVEL_O == {DAC_W{$past(TX_ACT_I)}}) else $error("transmit path wrong");
   cover property (wr_st && REG_WDATA_I[3:0] == 4'h9);
   cover property ($rose(SELF_TEST_START_O));
   cover property (aux_two_sel == 4'hc && TX_ACT_I);
endmodule // tdam_regs_monitor

//--- test_test_diag_aux_mux_regs.sv
// Self-checking testbench for the test and diagnostic register bank
`timescale 1ns/1ps
`include "tdam_defines.vh"
module test_test_diag_aux_mux_regs;
   reg clk = 1'b0;
   reg rst = 1'b1;
   reg [5:0] addr = 6'h00;
   reg [7:0] wdata = 8'h00;
   reg wr = 1'b0;
   reg rd = 1'b0;
   reg cmd_v = 1'b0;
   reg [3:0] cmd_c = 4'h0;
   reg tx = 1'b1;
   reg rx = 1'b0;
   reg subc = 1'b1;
   reg [7:0] tbus = 8'hdf;
   wire [7:0] rdata;
   wire st_en, st_go, nonlin, oe1, oe2;
   wire [4:0] tbsel;
   wire [5:0] l1, l2;
   integer err_total = 0;
   integer checks = 0;
   reg [7:0] d;
   reg [3:0] k;
   integer i;
   tdam_regs dut_u (.CLK_SYS_I(clk), .SYS_RST_I(rst), .REG_ADDR_I(addr), .REG_WDATA_I(wdata),
      .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdata), .CMD_VALID_I(cmd_v), .CMD_CODE_I(cmd_c),
      .CORR_I(6'h11), .MINLVL_I(6'h12), .ADC_I_I(6'h13), .ADC_Q_I(6'h14), .TX_ACT_I(tx),
      .RX_ACT_I(rx), .SUBC_DET_I(subc), .TEST_BUS_I(tbus), .SELF_TEST_EN_O(st_en),
      .SELF_TEST_START_O(st_go), .RX_NONLINEAR_O(nonlin), .TEST_BUS_SEL_O(tbsel),
      .AUX_ONE_LEVEL_O(l1), .AUX_ONE_OE_N_O(oe1), .AUX_TWO_LEVEL_O(l2), .AUX_TWO_OE_N_O(oe2));
   initial begin
      forever #2.5 clk = ~clk;
   end
   // ====================================================================
   // Shared tasks
   task chk(input [7:0] seen, input [7:0] exp);
      begin
         checks = checks + 1;
         if (seen !== exp) begin
            err_total = err_total + 1;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
         end
      end
   endtask
   task wrap_up;
      begin
         $display("checks %0d mismatches %0d", checks, err_total);
         if (err_total == 0 && checks > 0)
            $display("All checks passed");
         else
            $display("Checks failed");
         $finish;
      end
   endtask
   task wrt(input [5:0] a, input [7:0] v);
      begin
         @(posedge clk);
         addr <= a;
         wdata <= v;
         wr <= 1'b1;
         @(posedge clk);
         wr <= 1'b0;
      end
   endtask
   task rdr(input [5:0] a);
      begin
         @(posedge clk);
         addr <= a;
         rd <= 1'b1;
         @(posedge clk);
         rd <= 1'b0;
         @(negedge clk);
         d = rdata;
      end
   endtask
   task settle;
      begin
         repeat (3) @(posedge clk);
         @(negedge clk);
      end
   endtask
   task cmd(input [3:0] c);
      begin
         @(posedge clk);
         cmd_v <= 1'b1;
         cmd_c <= c;
         @(posedge clk);
         cmd_v <= 1'b0;
         @(negedge clk);
      end
   endtask
   // Expected level for the fixed probe values applied by this bench
   function [5:0] lvl(input [3:0] c, input two);
      case (c)
         4'h1: lvl = two ? 6'h15 : 6'h2a;
         4'h2: lvl = 6'h11;
         4'h4: lvl = 6'h12;
         4'h5: lvl = 6'h13;
         4'h6: lvl = 6'h14;
         4'ha, 4'hc, 4'he: lvl = 6'h3f;
         default: lvl = 6'h00;
      endcase
   endfunction
   function fl(input [3:0] c);
      fl = (c == 4'h0) || (c == 4'h3) || (c == 4'h7) || (c == 4'h8) || (c == 4'h9);
   endfunction
   // ====================================================================
   // Scenarios
   task t_reset;
      begin
         rdr(`TDAM_OFF_SELF_TEST);
         chk(d, 8'h40);
         chk({7'h0, nonlin}, 8'h01);
         rdr(`TDAM_OFF_AUX_SEL);
         chk(d, 8'h00);
         chk({6'h0, oe1, oe2}, 8'h03);
      end
   endtask
   task t_self;
      begin
         wrt(`TDAM_OFF_SELF_TEST, 8'h09);
         settle;
         chk({6'h0, st_en, nonlin}, 8'h02);
         cmd(4'h3);
         chk({7'h0, st_go}, 8'h01);
         cmd(4'h4);
         chk({7'h0, st_go}, 8'h00);
         wrt(`TDAM_OFF_SELF_TEST, 8'h40);
         settle;
         chk({6'h0, st_en, nonlin}, 8'h01);
         cmd(4'h3);
         chk({7'h0, st_go}, 8'h00);
      end
   endtask
   task t_id;
      begin
         wrt(`TDAM_OFF_CHIP_ID, 8'hff);
         rdr(`TDAM_OFF_CHIP_ID);
         chk(d, 8'h53);
         rdr(6'h00);
         chk(d, 8'h00);
      end
   endtask
   // Upper bits of probe DAC one are set so that a leak into its level shows up
   task t_aux;
      begin
         wrt(`TDAM_OFF_PROBE_ONE, 8'hea);
         wrt(`TDAM_OFF_PROBE_TWO, 8'h15);
         wrt(`TDAM_OFF_PROBE_SEL1, 8'h05);
         wrt(`TDAM_OFF_PROBE_SEL2, 8'hf7);
         settle;
         chk({3'h0, tbsel}, 8'h17);
         for (i = 0; i < 16; i = i + 1) begin
            k = i[3:0];
            wrt(`TDAM_OFF_AUX_SEL, {k, ~k});
            rdr(`TDAM_OFF_AUX_SEL);
            chk(d, {k, ~k});
            settle;
            chk({6'h0, oe1, oe2}, {6'h0, fl(k), fl(~k)});
            if (!fl(k))
               chk({2'h0, l1}, {2'h0, lvl(k, 1'b0)});
            if (!fl(~k))
               chk({2'h0, l2}, {2'h0, lvl(~k, 1'b1)});
         end
      end
   endtask
   // Activity, subcarrier and test-bus sources must follow their inputs
   task t_live;
      begin
         wrt(`TDAM_OFF_AUX_SEL, 8'hdc);
         tx <= 1'b0;
         rx <= 1'b1;
         settle;
         chk({2'h0, l1}, 8'h3f);
         chk({2'h0, l2}, 8'h00);
         chk({6'h0, oe1, oe2}, 8'h00);
         wrt(`TDAM_OFF_PROBE_SEL1, 8'h00);
         wrt(`TDAM_OFF_AUX_SEL, 8'hef);
         subc <= 1'b0;
         settle;
         settle;
         chk({2'h0, l1}, 8'h00);
         chk({2'h0, l2}, 8'h3f);
      end
   endtask
   // A second reset in mid-run must restore the reset values
   task t_rerun;
      begin
         @(posedge clk);
         rst <= 1'b1;
         repeat (2) @(posedge clk);
         rst <= 1'b0;
         t_reset;
      end
   endtask
   initial begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      t_reset;
      t_self;
      t_id;
      t_aux;
      t_live;
      t_rerun;
      wrap_up;
   end
   initial begin
      #20000;
      err_total = err_total + 1;
      wrap_up;
   end
endmodule // test_test_diag_aux_mux_regs
bind tdam_regs tdam_regs_monitor #(.CHIP_TYPE(CHIP_TYPE), .CHIP_REV(CHIP_REV), .DAC_W(DAC_W))
   mon_u (.CLK_SYS_I(CLK_SYS_I), .SYS_RST_I(SYS_RST_I), .REG_ADDR_I(REG_ADDR_I),
   .REG_WDATA_I(REG_WDATA_I), .REG_WR_I(REG_WR_I), .REG_RD_I(REG_RD_I),
   .REG_RDATA_O(REG_RDATA_O), .CMD_VALID_I(CMD_VALID_I), .CMD_CODE_I(CMD_CODE_I),
   .TX_ACT_I(TX_ACT_I), .SELF_TEST_EN_O(SELF_TEST_EN_O), .SELF_TEST_START_O(SELF_TEST_START_O),
   .RX_NONLINEAR_O(RX_NONLINEAR_O), .AUX_ONE_LEVEL_O(AUX_ONE_LEVEL_O),
   .AUX_ONE_OE_N_O(AUX_ONE_OE_N_O), .AUX_TWO_LEVEL_O(AUX_TWO_LEVEL_O),
   .AUX_TWO_OE_N_O(AUX_TWO_OE_N_O));
